/* File: rtl/rah_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: BCD hours: tens 0-2, ones 0-9
// R2: binary hours: bits 4:0, 0x00-0x17
// R3: counter mode: hours is counter byte 1
// R4: BCD select picks binary or BCD reading
// R5: reset leaves stored alarm values alone
// R6: BCD date: tens 0-3, ones 0-9
// R7: binary date: bits 4:0, 0x00-0x1e
// R8: counter mode: date is counter byte 0
// R9: BCD weekday code 1-7 in bits 2:0
// R10: binary weekday 0x01-0x07 in bits 2:0
// R11: software writes zero to reserved bits
// R12: mode bit: 0 calendar, 1 counter
// R13: only enabled fields join the match
// R14: alarm when all enabled fields match
module rah_regs (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [13:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic [7:0] cur_hrs, // hours or counter byte 1
  input wire logic [7:0] cur_dom, // date or counter byte 0
  input wire logic [7:0] cur_dow, // current weekday
  output logic alarm, // all enabled fields match
  output logic irq // unmasked status pending
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] ctrl;
    logic [1:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic alarm;
    logic irq;
  } rah_state_s;

  typedef struct packed {
    logic [7:0] hrs;
    logic [7:0] dom;
    logic [7:0] dow;
  } rah_alarm_s;

  rah_state_s q;
  rah_state_s d;
  rah_alarm_s aq;
  rah_alarm_s ad;
  logic [11:0] idx;
  logic setup;
  logic wr;
  logic mode;
  logic bcd;
  logic ev_bad;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic [31:0] rdv;

  rah_match_if mif ();

  function automatic logic mapped(logic [11:0] i);
    return i == rah_pkg::IDX_HOURS || i == rah_pkg::IDX_DOM || i == rah_pkg::IDX_DOW ||
           i == rah_pkg::IDX_CTRL || i == rah_pkg::IDX_CFG || i == rah_pkg::IDX_STAT ||
           i == rah_pkg::IDX_MASK;
  endfunction

  // ----------------------------------------
  // comparator
  // ----------------------------------------
  assign mif.al_hrs = aq.hrs;
  assign mif.al_dom = aq.dom;
  assign mif.al_dow = aq.dow;
  assign mif.en_hrs = q.ctrl[rah_pkg::CTRL_HRS];
  assign mif.en_dom = q.ctrl[rah_pkg::CTRL_DOM];
  assign mif.en_dow = q.ctrl[rah_pkg::CTRL_DOW];
  assign mif.mode = mode;
  assign mif.bcd = bcd;
  assign mif.cur_hrs = cur_hrs;
  assign mif.cur_dom = cur_dom;
  assign mif.cur_dow = cur_dow;

  rah_match u_cmp (
    .m (mif.cmp)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    ad = aq;
    idx = paddr[13:2];
    mode = q.cfg[rah_pkg::CFG_MODE]; // R12
    bcd = q.cfg[rah_pkg::CFG_BCD]; // R4
    setup = psel & ~penable & ~q.pready;
    wr = psel & penable & q.pready & pwrite;
    ev_bad = 1'b0;
    w1c = 2'h0;
    rdv = 32'h0000_0000;
    case (idx)
      rah_pkg::IDX_HOURS: begin
        rdv[7:0] = aq.hrs;
      end
      rah_pkg::IDX_DOM: begin
        rdv[7:0] = aq.dom;
      end
      rah_pkg::IDX_DOW: begin
        rdv[7:0] = aq.dow & rah_pkg::DOW_WMASK;
      end
      rah_pkg::IDX_CTRL: begin
        rdv[7:0] = q.ctrl;
      end
      rah_pkg::IDX_CFG: begin
        rdv[1:0] = q.cfg;
      end
      rah_pkg::IDX_STAT: begin
        rdv[1:0] = q.stat;
      end
      rah_pkg::IDX_MASK: begin
        rdv[1:0] = q.mask;
      end
      default: begin
        rdv = 32'h0000_0000;
      end
    endcase
    // answer one cycle after the setup phase
    d.pready = setup;
    if (setup) begin
      d.prdata = pwrite ? 32'h0000_0000 : rdv;
      d.pslverr = ~mapped(idx);
    end
    // writes take effect at the completing access edge
    if (wr) begin
      case (idx)
        rah_pkg::IDX_HOURS: begin
          ad.hrs = pwdata[7:0]; // R3
          ev_bad = ~rah_pkg::rah_valid(rah_pkg::RAH_F_HRS, mode, bcd, pwdata[7:0]); // R1 R2
        end
        rah_pkg::IDX_DOM: begin
          ad.dom = pwdata[7:0]; // R8
          ev_bad = ~rah_pkg::rah_valid(rah_pkg::RAH_F_DOM, mode, bcd, pwdata[7:0]); // R4 R6 R7
        end
        rah_pkg::IDX_DOW: begin
          ad.dow = pwdata[7:0] & rah_pkg::DOW_WMASK; // R11
          ev_bad = ~rah_pkg::rah_valid(rah_pkg::RAH_F_DOW, mode, bcd, pwdata[7:0]); // R9 R10
        end
        rah_pkg::IDX_CTRL: begin
          d.ctrl = pwdata[7:0] & rah_pkg::CTRL_WMASK; // R13
        end
        rah_pkg::IDX_CFG: begin
          d.cfg = pwdata[1:0]; // R12
        end
        rah_pkg::IDX_STAT: begin
          w1c = pwdata[1:0];
        end
        rah_pkg::IDX_MASK: begin
          d.mask = pwdata[1:0];
        end
        default: begin
          w1c = 2'h0;
        end
      endcase
    end
    // new events win over a same-cycle clear
    ev = 2'h0;
    ev[rah_pkg::ST_HIT] = mif.hit & ~q.alarm; // R14
    ev[rah_pkg::ST_BAD] = ev_bad;
    d.stat = (q.stat & ~w1c) | ev;
    d.alarm = mif.hit; // R14
    d.irq = |(d.stat & d.mask);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.pready <= 1'b0;
      q.prdata <= 32'h0000_0000;
      q.pslverr <= 1'b0;
      q.ctrl <= rah_pkg::CTRL_RST;
      q.cfg <= rah_pkg::CFG_RST;
      q.stat <= rah_pkg::ST_RST;
      q.mask <= rah_pkg::MASK_RST;
      q.alarm <= 1'b0;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // alarm values carry no reset
  always_ff @(posedge pclk) begin
    aq <= ad; // R5
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign alarm = q.alarm;
  assign irq = q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_hrs;
    wr && idx == rah_pkg::IDX_HOURS;
  endsequence

  sequence s_wr_dom;
    wr && idx == rah_pkg::IDX_DOM;
  endsequence

  sequence s_wr_dow;
    wr && idx == rah_pkg::IDX_DOW;
  endsequence

  hrs_bcd_tens_a: assert property ( // R1
    s_wr_hrs ##0 (!mode && bcd && pwdata[rah_pkg::TENS_HI:rah_pkg::TENS_LO] > rah_pkg::HRS_TENS_MAX)
    |=> q.stat[rah_pkg::ST_BAD])
    else $error("bcd hours tens above limit not flagged");

  hrs_bin_range_a: assert property ( // R2
    s_wr_hrs ##0 (!mode && !bcd && pwdata[7:0] > rah_pkg::HRS_BIN_MAX)
    |=> q.stat[rah_pkg::ST_BAD] && aq.hrs == $past(pwdata[7:0]))
    else $error("binary hours above limit not flagged");

  hrs_count_byte_a: assert property ( // R3
    s_wr_hrs ##0 mode |-> !ev_bad ##1 aq.hrs == $past(pwdata[7:0]))
    else $error("counter byte 1 not stored whole");

  dom_bcd_ones_a: assert property ( // R4
    s_wr_dom ##0 (!mode && bcd && pwdata[3:0] > rah_pkg::ONES_MAX)
    |=> q.stat[rah_pkg::ST_BAD])
    else $error("bcd date ones digit above nine not flagged");

  dom_bcd_tens_a: assert property ( // R6
    s_wr_dom ##0 (!mode && bcd && pwdata[7:6] == 2'h0 && pwdata[3:0] <= rah_pkg::ONES_MAX)
    |-> !ev_bad ##1 aq.dom == $past(pwdata[7:0]))
    else $error("bcd date with tens 0-3 flagged or lost");

  dom_bin_range_a: assert property ( // R7
    s_wr_dom ##0 (!mode && !bcd && pwdata[7:0] > rah_pkg::DOM_BIN_MAX)
    |=> q.stat[rah_pkg::ST_BAD])
    else $error("binary date above limit not flagged");

  dom_count_byte_a: assert property ( // R8
    s_wr_dom ##0 mode |-> !ev_bad ##1 aq.dom == $past(pwdata[7:0]))
    else $error("counter byte 0 not stored whole");

  dow_code_zero_a: assert property ( // R9
    s_wr_dow ##0 (pwdata[2:0] == 3'h0) |=> q.stat[rah_pkg::ST_BAD])
    else $error("weekday code zero not flagged");

  dow_low_bits_a: assert property ( // R10
    s_wr_dow |=> aq.dow == ($past(pwdata[7:0]) & rah_pkg::DOW_WMASK))
    else $error("weekday not kept in bits 2:0");

  dow_counter_off_a: assert property ( // R12
    (mode && q.ctrl == (8'h01 << rah_pkg::CTRL_DOW)) |=> !q.alarm)
    else $error("weekday enable used in counter mode");

  no_enable_idle_a: assert property ( // R13
    (q.ctrl == rah_pkg::CTRL_RST) |=> !q.alarm)
    else $error("alarm with every field disabled");

  alarm_sets_stat_a: assert property ( // R14
    $rose(q.alarm) |-> q.stat[rah_pkg::ST_HIT])
    else $error("alarm rise left status clear");

  hrs_match_a: assert property ( // R14
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_HRS]) && $past(mode)) |-> $past(aq.hrs) == $past(cur_hrs))
    else $error("counter byte 1 mismatch raised alarm");

  ready_pulse_a: assert property (
    q.pready |=> !q.pready)
    else $error("ready held longer than one cycle");

  irq_level_a: assert property (
    (q.stat & q.mask) != 2'h0 |-> q.irq)
    else $error("unmasked status without interrupt");

  sequence s_setup_unmapped;
    setup && !mapped(idx);
  endsequence

  sequence s_clear_hit;
    wr && idx == rah_pkg::IDX_STAT && pwdata[rah_pkg::ST_HIT] && !ev[rah_pkg::ST_HIT];
  endsequence

  unmapped_err_a: assert property (
    s_setup_unmapped |=> q.pready && q.pslverr && q.prdata == 32'h0000_0000)
    else $error("unmapped access without error response");

  read_upper_zero_a: assert property (
    q.pready |-> q.prdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");

  stat_clear_a: assert property (
    s_clear_hit |=> !q.stat[rah_pkg::ST_HIT])
    else $error("write one left alarm status set");

  hrs_bcd_width_a: assert property ( // R1
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_HRS]) && !$past(mode) && $past(bcd))
    |-> $past(aq.hrs[5:0]) == $past(cur_hrs[5:0]))
    else $error("bcd hours compare ignored a digit bit");

  hrs_bin_width_a: assert property ( // R2
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_HRS]) && !$past(mode) && !$past(bcd))
    |-> $past(aq.hrs[4:0]) == $past(cur_hrs[4:0]))
    else $error("binary hours compare ignored a value bit");

  dom_bcd_width_a: assert property ( // R6
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_DOM]) && !$past(mode) && $past(bcd))
    |-> $past(aq.dom[5:0]) == $past(cur_dom[5:0]))
    else $error("bcd date compare ignored a digit bit");

  dom_bin_width_a: assert property ( // R7
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_DOM]) && !$past(mode) && !$past(bcd))
    |-> $past(aq.dom[4:0]) == $past(cur_dom[4:0]))
    else $error("binary date compare ignored a value bit");

  dom_match_a: assert property ( // R8
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_DOM]) && $past(mode)) |-> $past(aq.dom) == $past(cur_dom))
    else $error("counter byte 0 mismatch raised alarm");

  dow_match_a: assert property ( // R10
    (q.alarm && $past(q.ctrl[rah_pkg::CTRL_DOW]) && !$past(mode))
    |-> $past(aq.dow[2:0]) == $past(cur_dow[2:0]))
    else $error("weekday mismatch raised alarm");

  alarm_needs_en_a: assert property ( // R13
    q.alarm |-> $past(q.ctrl[rah_pkg::CTRL_HRS] || q.ctrl[rah_pkg::CTRL_DOM] ||
                      (q.ctrl[rah_pkg::CTRL_DOW] && !mode)))
    else $error("alarm without an enabled field");
endmodule
`default_nettype wire

/* File: include/rah_pkg.sv */
package rah_pkg;
  // ----------------------------------------
  // register map: index, byte address = 4 * index
  // ----------------------------------------
  localparam int unsigned AW = 14;
  localparam logic [11:0] IDX_HOURS = 12'hf39;
  localparam logic [11:0] IDX_DOM = 12'hf3a;
  localparam logic [11:0] IDX_DOW = 12'hf3b;
  localparam logic [11:0] IDX_CTRL = 12'hf3c;
  localparam logic [11:0] IDX_CFG = 12'hf40;
  localparam logic [11:0] IDX_STAT = 12'hf41;
  localparam logic [11:0] IDX_MASK = 12'hf42;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_DOM = 4;
  localparam int unsigned CTRL_DOW = 3;
  localparam int unsigned CTRL_HRS = 2;
  localparam logic [7:0] CTRL_WMASK = 8'h1f;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DOW_WMASK = 8'h07;
  localparam int unsigned CFG_MODE = 0;
  localparam int unsigned CFG_BCD = 1;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam int unsigned ST_HIT = 0;
  localparam int unsigned ST_BAD = 1;
  localparam logic [1:0] ST_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam int unsigned TENS_HI = 5;
  localparam int unsigned TENS_LO = 4;

  // ----------------------------------------
  // value limits and compare masks
  // ----------------------------------------
  localparam logic [1:0] HRS_TENS_MAX = 2'h2;
  localparam logic [1:0] DOM_TENS_MAX = 2'h3;
  localparam logic [3:0] ONES_MAX = 4'h9;
  localparam logic [7:0] HRS_BIN_MAX = 8'h17;
  localparam logic [7:0] DOM_BIN_MAX = 8'h1e;
  localparam logic [2:0] DOW_MIN = 3'h1;
  localparam logic [7:0] MASK_COUNT = 8'hff;
  localparam logic [7:0] MASK_BCD = 8'h3f;
  localparam logic [7:0] MASK_BIN = 8'h1f;

  typedef enum logic [1:0] {RAH_F_HRS, RAH_F_DOM, RAH_F_DOW} rah_field_e;

  function automatic logic [7:0] rah_cmp_mask(rah_field_e f, logic mode, logic bcd);
    logic [7:0] m;
    m = mode ? MASK_COUNT : (bcd ? MASK_BCD : MASK_BIN);
    if (f == RAH_F_DOW) begin
      m = DOW_WMASK;
    end
    return m;
  endfunction

  function automatic logic rah_valid(rah_field_e f, logic mode, logic bcd, logic [7:0] v);
    logic ok;
    logic tens_ok;
    ok = 1'b1;
    tens_ok = (f == RAH_F_HRS) ? (v[5:4] <= HRS_TENS_MAX) : (v[5:4] <= DOM_TENS_MAX);
    if (f == RAH_F_DOW) begin
      ok = v[2:0] >= DOW_MIN;
    end else if (!mode && bcd) begin
      ok = (v[7:6] == 2'h0) && tens_ok && (v[3:0] <= ONES_MAX);
    end else if (!mode) begin
      ok = v <= ((f == RAH_F_HRS) ? HRS_BIN_MAX : DOM_BIN_MAX);
    end
    return ok;
  endfunction
endpackage

/* File: include/rah_match_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface rah_match_if;
  logic [7:0] al_hrs;
  logic [7:0] al_dom;
  logic [7:0] al_dow;
  logic en_hrs;
  logic en_dom;
  logic en_dow;
  logic mode;
  logic bcd;
  logic [7:0] cur_hrs;
  logic [7:0] cur_dom;
  logic [7:0] cur_dow;
  logic hit;
  modport regs (output al_hrs, al_dom, al_dow, en_hrs, en_dom, en_dow, mode, bcd,
                output cur_hrs, cur_dom, cur_dow, input hit);
  modport cmp (input al_hrs, al_dom, al_dow, en_hrs, en_dom, en_dow, mode, bcd,
               input cur_hrs, cur_dom, cur_dow, output hit);
endinterface
`default_nettype wire

/* File: rtl/rah_match.sv */
`timescale 1ns/1ns
`default_nettype none
module rah_match (
  rah_match_if.cmp m // alarm values, enables, current time
);
  logic [7:0] mh;
  logic [7:0] md;
  logic [7:0] mw;
  logic eq_h;
  logic eq_d;
  logic eq_w;
  logic dow_on;
  logic any_on;

  // ----------------------------------------
  // field compare
  // ----------------------------------------
  always_comb begin
    mh = rah_pkg::rah_cmp_mask(rah_pkg::RAH_F_HRS, m.mode, m.bcd); // R1 R2 R3
    md = rah_pkg::rah_cmp_mask(rah_pkg::RAH_F_DOM, m.mode, m.bcd); // R6 R7 R8
    mw = rah_pkg::rah_cmp_mask(rah_pkg::RAH_F_DOW, m.mode, m.bcd); // R9 R10
    eq_h = ((m.al_hrs ^ m.cur_hrs) & mh) == 8'h00;
    eq_d = ((m.al_dom ^ m.cur_dom) & md) == 8'h00;
    eq_w = ((m.al_dow ^ m.cur_dow) & mw) == 8'h00;
    // weekday has no byte in counter mode
    dow_on = m.en_dow & ~m.mode; // R12
    any_on = m.en_hrs | m.en_dom | dow_on; // R13
    m.hit = any_on & (~m.en_hrs | eq_h) & (~m.en_dom | eq_d) & (~dow_on | eq_w); // R14
  end
endmodule
`default_nettype wire

/* File: tb/rah_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module rah_regs_test;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] cur_hrs = 8'h00;
  logic [7:0] cur_dom = 8'h00;
  logic [7:0] cur_dow = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarm;
  logic irq;
  logic [31:0] rng = 32'h27;
  logic [9:0] exp_q[$]; // write, slave error, read data
  logic [22:0] bad_t [12] = '{
    {1'b1, 2'h0, 12'hf39, 8'h18}, {1'b0, 2'h0, 12'hf39, 8'h17}, {1'b1, 2'h2, 12'hf39, 8'h30},
    {1'b0, 2'h2, 12'hf39, 8'h29}, {1'b1, 2'h2, 12'hf39, 8'h1a}, {1'b1, 2'h0, 12'hf3a, 8'h1f},
    {1'b0, 2'h0, 12'hf3a, 8'h1e}, {1'b1, 2'h2, 12'hf3a, 8'h3a}, {1'b0, 2'h2, 12'hf3a, 8'h39},
    {1'b1, 2'h0, 12'hf3b, 8'h00}, {1'b0, 2'h2, 12'hf3b, 8'h07}, {1'b0, 2'h1, 12'hf39, 8'hff}};
  int n_errors = 0;
  int n_checks = 0;

  rah_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_hrs(cur_hrs), .cur_dom(cur_dom), .cur_dow(cur_dow), .alarm(alarm), .irq(irq));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [7:0] e,
                     input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    exp_q.push_back({w, err, e});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, e, 1'b0);
  endtask

  task automatic cur(input logic [7:0] h, input logic [7:0] d, input logic [7:0] w, input logic ea,
                     input logic ei);
    @(posedge pclk);
    cur_hrs <= h;
    cur_dom <= d;
    cur_dow <= w;
    @(posedge pclk);
    @(negedge pclk);
    check({7'h0, alarm}, {7'h0, ea}, "alarm");
    check({7'h0, irq}, {7'h0, ei}, "irq");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // response monitor: oldest note against each completed transfer
  // ----------------------------------------
  always @(posedge pclk) begin
    logic [9:0] e;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
      check({7'h0, pslverr}, {7'h0, e[8]}, "slave error");
      if (e[9] === 1'b0) begin
        check(prdata[7:0], e[7:0], "read data");
        check({7'h0, |prdata[31:8]}, 8'h00, "upper read bits");
      end
    end
  end

  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] v;
    logic [7:0] m;
    int i;
    int k;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(rah_pkg::IDX_CTRL, rah_pkg::CTRL_RST);
    rd(rah_pkg::IDX_CFG, {6'h0, rah_pkg::CFG_RST});
    rd(rah_pkg::IDX_STAT, {6'h0, rah_pkg::ST_RST});
    rd(rah_pkg::IDX_MASK, {6'h0, rah_pkg::MASK_RST});
    apb(1'b0, 12'hf3d, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 12'hf3d, 8'h5a, 8'h00, 1'b1);
    // counter mode: random bytes stored whole, weekday enable ignored
    wr(rah_pkg::IDX_CFG, 8'h01);
    rng = xs(rng);
    a = rng[7:0];
    b = rng[15:8];
    v = (rng[18:16] == 3'h0) ? 8'h01 : {5'h0, rng[18:16]};
    wr(rah_pkg::IDX_HOURS, a);
    wr(rah_pkg::IDX_DOM, b);
    wr(rah_pkg::IDX_DOW, v);
    rd(rah_pkg::IDX_HOURS, a);
    rd(rah_pkg::IDX_DOM, b);
    rd(rah_pkg::IDX_DOW, v);
    wr(rah_pkg::IDX_DOW, 8'h07);
    rd(rah_pkg::IDX_DOW, 8'h07);
    wr(rah_pkg::IDX_MASK, 8'h01);
    wr(rah_pkg::IDX_CTRL, 8'h1c);
    cur(a, b, ~v, 1'b1, 1'b1);
    cur(a, b ^ 8'h80, v, 1'b0, 1'b1);
    wr(rah_pkg::IDX_STAT, 8'h01);
    rd(rah_pkg::IDX_STAT, 8'h00);
    cur(a ^ 8'h80, b, v, 1'b0, 1'b0);
    // reset in mid-run keeps the alarm values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(rah_pkg::IDX_HOURS, a);
    rd(rah_pkg::IDX_DOM, b);
    rd(rah_pkg::IDX_DOW, 8'h07);
    rd(rah_pkg::IDX_CTRL, 8'h00);
    // per-mode compare width of hours and date
    wr(rah_pkg::IDX_HOURS, 8'h13);
    wr(rah_pkg::IDX_DOM, 8'h13);
    wr(rah_pkg::IDX_DOW, 8'h03);
    for (i = 0; i < 6; i++) begin
      m = (i % 3 == 2) ? 8'hff : ((i % 3 == 1) ? 8'h3f : 8'h1f);
      wr(rah_pkg::IDX_CFG, (i % 3 == 2) ? 8'h01 : ((i % 3 == 1) ? 8'h02 : 8'h00));
      wr(rah_pkg::IDX_CTRL, (i < 3) ? 8'h04 : 8'h10);
      for (k = 4; k < 8; k++) begin
        v = 8'h13 ^ (8'h01 << k);
        if (i < 3) begin
          cur(v, 8'h13, 8'h03, ~|(m & (8'h01 << k)), 1'b0);
        end else begin
          cur(8'h13, v, 8'h03, ~|(m & (8'h01 << k)), 1'b0);
        end
      end
      cur(8'h13, 8'h13, 8'h03, 1'b1, 1'b0);
    end
    // weekday and no-enable cases
    for (i = 0; i < 3; i++) begin
      wr(rah_pkg::IDX_CFG, (i == 2) ? 8'h01 : ((i == 1) ? 8'h02 : 8'h00));
      wr(rah_pkg::IDX_CTRL, 8'h08);
      cur(8'h13, 8'h13, 8'h02, 1'b0, 1'b0);
      cur(8'h13, 8'h13, 8'h03, i != 2, 1'b0);
    end
    wr(rah_pkg::IDX_CTRL, 8'h00);
    cur(8'h13, 8'h13, 8'h02, 1'b0, 1'b0);
    // out-of-range writes flag the status bit and the interrupt
    wr(rah_pkg::IDX_MASK, 8'h02);
    for (i = 0; i < 12; i++) begin
      wr(rah_pkg::IDX_CFG, {6'h0, bad_t[i][21:20]});
      wr(rah_pkg::IDX_STAT, 8'h03);
      wr(bad_t[i][19:8], bad_t[i][7:0]);
      rd(rah_pkg::IDX_STAT, {6'h0, bad_t[i][22], 1'b0});
      @(negedge pclk);
      check({7'h0, irq}, {7'h0, bad_t[i][22]}, "error irq");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
